// file: core/dcs_pkg.sv
// constants and types shared by the drive command source selector
// assumes one controller clock; mode codes arrive as 8-bit binary numbers
package dcs_pkg;

  // ************************************************
  // mode codes
  // ************************************************
  localparam int MODE_W = 8;
  localparam logic [7:0] MODE_CONTACTS = 8'h00;
  localparam logic [7:0] MODE_STATE_MACHINE = 8'h01;
  localparam logic [7:0] MODE_REMOTE = 8'h02;
  localparam logic [7:0] MODE_KEY_DIR_CONT = 8'h03;
  localparam logic [7:0] MODE_EITHER_DIR_CONT = 8'h04;
  localparam logic [7:0] MODE_3W_DIR_CONT = 8'h05;
  localparam logic [7:0] MODE_KEY_DIR_KEY = 8'h0D;
  localparam logic [7:0] MODE_EITHER_DIR_KEY = 8'h0E;
  localparam logic [7:0] MODE_CONT_CW = 8'h14;
  localparam logic [7:0] MODE_KEY_CW = 8'h17;
  localparam logic [7:0] MODE_EITHER_CW = 8'h18;
  localparam logic [7:0] MODE_CONT_CCW = 8'h1E;
  localparam logic [7:0] MODE_KEY_CCW = 8'h21;
  localparam logic [7:0] MODE_EITHER_CCW = 8'h22;
  localparam logic [7:0] MODE_KEY_DIR_EITHER = 8'h2B;
  localparam logic [7:0] MODE_EITHER_DIR_EITHER = 8'h2C;
  localparam logic [7:0] MODE_3W_KEY_DIR_EITHER = 8'h2E;

  // ************************************************
  // reset values
  // ************************************************
  localparam logic [7:0] MODE_RESET = MODE_CONTACTS;
  localparam logic DIR_RESET = 1'b0;

  // ************************************************
  // source selections and run state
  // ************************************************
  typedef enum logic [2:0] {
    START_CONT = 3'h0,
    START_KEY = 3'h1,
    START_EITHER = 3'h2,
    START_SM = 3'h3,
    START_REM = 3'h4,
    START_3W = 3'h5,
    START_3W_KEY = 3'h6
  } dcs_start_src_t;

  typedef enum logic [2:0] {
    DIR_CONT = 3'h0,
    DIR_KEY = 3'h1,
    DIR_EITHER = 3'h2,
    DIR_SM = 3'h3,
    DIR_REM = 3'h4,
    DIR_FIX_CW = 3'h5,
    DIR_FIX_CCW = 3'h6
  } dcs_dir_src_t;

  typedef enum logic {
    RUN_STOPPED = 1'b0,
    RUN_RUNNING = 1'b1
  } dcs_run_state_t;

endpackage

// file: core/dcs_sync.sv
// two-flop synchroniser for a group of pin levels
// assumes each bit is an independent slow level; no multi-bit coherence
`timescale 1ns/1ns
`default_nettype none
module dcs_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// file: core/dcs_three_wire.sv
// three-wire run latch: start pulses set it, an open hold contact clears it
// assumes inputs are already synchronised to clk
`timescale 1ns/1ns
`default_nettype none
module dcs_three_wire (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // controls
  input wire logic start_pulse,
  input wire logic stop_req,
  input wire logic preset,
  // state
  output logic running
);

  // stop wins: a held-open stop contact must never be overridden by a start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      running <= 1'b0;
    end else if (stop_req) begin
      running <= 1'b0;
    end else if (start_pulse || preset) begin
      running <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// file: core/dcs_selector.sv
// drive command source selector: picks start/stop and direction sources by mode
// assumes keypad, state machine and remote signals come from logic on CLOCK;
// contact and safe-stop pins are asynchronous and synchronised here
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - mode 0: everything from contacts
// - mode 1: everything from communication state machine
// - mode 2: everything from remote virtual contacts
// - mode 3: keypad start/stop, contact direction
// - mode 4: keypad or contacts, contact direction
// - mode 5: three-wire, contact direction
// - mode 13: everything from keypad
// - mode 14: keypad or contacts, keypad direction
// - modes 20/23/24 force clockwise
// - modes 30/33/34 force anticlockwise likewise
// - mode 43: keypad start/stop, either direction
// - mode 44: everything from keypad or contacts
// - mode 46: three-wire plus keypad, either direction
// - mode change into a keypad-fed or three-wire mode keeps running unless stop
// - output stage needs both safe-stop inputs high
module dcs_selector (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // mode selection
  input wire logic [7:0] MODE_CODE,
  input wire logic MODE_WRITE,
  // digital contacts (asynchronous pins)
  input wire logic CONT_START_CW,
  input wire logic CONT_START_CCW,
  input wire logic CONT_3W_HOLD,
  // keypad
  input wire logic KEYPAD_SOURCE_START,
  input wire logic KEYPAD_SOURCE_STOP,
  input wire logic KEYPAD_SOURCE_DIR_CCW,
  // communication state machine
  input wire logic SM_RUN,
  input wire logic SM_DIR_CCW,
  // remote virtual contacts
  input wire logic REM_START_CW,
  input wire logic REM_START_CCW,
  // safe stop (asynchronous pins)
  input wire logic SAFE_STOP_INPUT_A,
  input wire logic SAFE_STOP_INPUT_B,
  // results
  output logic RUN_CMD,
  output logic DIR_CCW,
  output logic OUTPUT_ENABLE,
  output logic [7:0] ACTIVE_MODE,
  output logic MODE_REJECTED
);

  // ************************************************
  // pin synchronisation
  // ************************************************
  logic [4:0] pins_sync;
  logic c_cw;
  logic c_ccw;
  logic c_hold;
  logic ss_a;
  logic ss_b;

  dcs_sync #(
    .WIDTH(5)
  ) u_sync (
    .clk(CLOCK),
    .rst(RESET),
    .async_in({SAFE_STOP_INPUT_B, SAFE_STOP_INPUT_A, CONT_3W_HOLD, CONT_START_CCW,
      CONT_START_CW}),
    .sync_out(pins_sync)
  );

  assign c_cw = pins_sync[0];
  assign c_ccw = pins_sync[1];
  assign c_hold = pins_sync[2];
  assign ss_a = pins_sync[3];
  assign ss_b = pins_sync[4];

  // ************************************************
  // mode register
  // ************************************************
  logic [7:0] mode_reg;
  logic mode_valid;
  logic mode_accept;
  logic [7:0] eff_mode;

  function automatic logic code_listed(input logic [7:0] code);
    case (code)
      dcs_pkg::MODE_CONTACTS, dcs_pkg::MODE_STATE_MACHINE, dcs_pkg::MODE_REMOTE,
      dcs_pkg::MODE_KEY_DIR_CONT, dcs_pkg::MODE_EITHER_DIR_CONT,
      dcs_pkg::MODE_3W_DIR_CONT, dcs_pkg::MODE_KEY_DIR_KEY,
      dcs_pkg::MODE_EITHER_DIR_KEY, dcs_pkg::MODE_CONT_CW, dcs_pkg::MODE_KEY_CW,
      dcs_pkg::MODE_EITHER_CW, dcs_pkg::MODE_CONT_CCW, dcs_pkg::MODE_KEY_CCW,
      dcs_pkg::MODE_EITHER_CCW, dcs_pkg::MODE_KEY_DIR_EITHER,
      dcs_pkg::MODE_EITHER_DIR_EITHER, dcs_pkg::MODE_3W_KEY_DIR_EITHER: begin
        code_listed = 1'b1;
      end
      default: begin
        code_listed = 1'b0;
      end
    endcase
  endfunction

  assign mode_valid = code_listed(MODE_CODE);
  assign mode_accept = MODE_WRITE && mode_valid && (MODE_CODE != mode_reg);
  // decode the incoming mode in its accept cycle so latches can be preset
  assign eff_mode = mode_accept ? MODE_CODE : mode_reg;

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      mode_reg <= dcs_pkg::MODE_RESET;
    end else if (mode_accept) begin
      mode_reg <= MODE_CODE;
    end
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      MODE_REJECTED <= 1'b0;
    end else begin
      MODE_REJECTED <= MODE_WRITE && !mode_valid;
    end
  end

  assign ACTIVE_MODE = mode_reg;

  // ************************************************
  // source decode
  // ************************************************
  dcs_pkg::dcs_start_src_t start_src;
  dcs_pkg::dcs_dir_src_t dir_src;

  always_comb begin
    case (eff_mode)
      dcs_pkg::MODE_CONTACTS: begin
        start_src = dcs_pkg::START_CONT;
        dir_src = dcs_pkg::DIR_CONT;
      end
      dcs_pkg::MODE_STATE_MACHINE: begin
        start_src = dcs_pkg::START_SM;
        dir_src = dcs_pkg::DIR_SM;
      end
      dcs_pkg::MODE_REMOTE: begin
        start_src = dcs_pkg::START_REM;
        dir_src = dcs_pkg::DIR_REM;
      end
      dcs_pkg::MODE_KEY_DIR_CONT: begin
        start_src = dcs_pkg::START_KEY;
        dir_src = dcs_pkg::DIR_CONT;
      end
      dcs_pkg::MODE_EITHER_DIR_CONT: begin
        start_src = dcs_pkg::START_EITHER;
        dir_src = dcs_pkg::DIR_CONT;
      end
      dcs_pkg::MODE_3W_DIR_CONT: begin
        start_src = dcs_pkg::START_3W;
        dir_src = dcs_pkg::DIR_CONT;
      end
      dcs_pkg::MODE_KEY_DIR_KEY: begin
        start_src = dcs_pkg::START_KEY;
        dir_src = dcs_pkg::DIR_KEY;
      end
      dcs_pkg::MODE_EITHER_DIR_KEY: begin
        start_src = dcs_pkg::START_EITHER;
        dir_src = dcs_pkg::DIR_KEY;
      end
      dcs_pkg::MODE_CONT_CW: begin
        start_src = dcs_pkg::START_CONT;
        dir_src = dcs_pkg::DIR_FIX_CW;
      end
      dcs_pkg::MODE_KEY_CW: begin
        start_src = dcs_pkg::START_KEY;
        dir_src = dcs_pkg::DIR_FIX_CW;
      end
      dcs_pkg::MODE_EITHER_CW: begin
        start_src = dcs_pkg::START_EITHER;
        dir_src = dcs_pkg::DIR_FIX_CW;
      end
      dcs_pkg::MODE_CONT_CCW: begin
        start_src = dcs_pkg::START_CONT;
        dir_src = dcs_pkg::DIR_FIX_CCW;
      end
      dcs_pkg::MODE_KEY_CCW: begin
        start_src = dcs_pkg::START_KEY;
        dir_src = dcs_pkg::DIR_FIX_CCW;
      end
      dcs_pkg::MODE_EITHER_CCW: begin
        start_src = dcs_pkg::START_EITHER;
        dir_src = dcs_pkg::DIR_FIX_CCW;
      end
      dcs_pkg::MODE_KEY_DIR_EITHER: begin
        start_src = dcs_pkg::START_KEY;
        dir_src = dcs_pkg::DIR_EITHER;
      end
      dcs_pkg::MODE_EITHER_DIR_EITHER: begin
        start_src = dcs_pkg::START_EITHER;
        dir_src = dcs_pkg::DIR_EITHER;
      end
      dcs_pkg::MODE_3W_KEY_DIR_EITHER: begin
        start_src = dcs_pkg::START_3W_KEY;
        dir_src = dcs_pkg::DIR_EITHER;
      end
      default: begin
        start_src = dcs_pkg::START_CONT;
        dir_src = dcs_pkg::DIR_CONT;
      end
    endcase
  end

  // ************************************************
  // keypad and three-wire latches
  // ************************************************
  dcs_pkg::dcs_run_state_t run_state;
  logic running;
  logic key_run_reg;
  logic key_run_next;
  logic c_start_prev_reg;
  logic c_start_pulse;
  logic tw_start;
  logic tw_stop;
  logic tw_preset;
  logic tw_run;
  logic tw_key_mode;
  logic tw_sel;
  logic key_sel;

  assign running = (run_state == dcs_pkg::RUN_RUNNING);
  // only a keypad-fed target inherits the run; otherwise a stale latch would start later
  assign key_sel = (start_src == dcs_pkg::START_KEY) || (start_src == dcs_pkg::START_EITHER);

  // preset held sources so a mode change alone does not stop the drive
  always_comb begin
    key_run_next = key_run_reg;
    if (KEYPAD_SOURCE_STOP) begin
      key_run_next = 1'b0;
    end else if (KEYPAD_SOURCE_START) begin
      key_run_next = 1'b1;
    end else if (mode_accept && running && key_sel) begin
      key_run_next = 1'b1;
    end
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      key_run_reg <= 1'b0;
    end else begin
      key_run_reg <= key_run_next;
    end
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      c_start_prev_reg <= 1'b0;
    end else begin
      c_start_prev_reg <= c_cw || c_ccw;
    end
  end

  assign c_start_pulse = (c_cw || c_ccw) && !c_start_prev_reg;
  assign tw_key_mode = (start_src == dcs_pkg::START_3W_KEY);
  assign tw_sel = (start_src == dcs_pkg::START_3W) || tw_key_mode;

  // in three-wire plus keypad mode the keypad also starts and stops
  // latch held clear outside three-wire modes: entering one must not start the drive
  assign tw_start = tw_sel && (c_start_pulse || (tw_key_mode && KEYPAD_SOURCE_START));
  assign tw_stop = !tw_sel || !c_hold || (tw_key_mode && KEYPAD_SOURCE_STOP);
  // three-wire keeps running if hold contact closed
  assign tw_preset = mode_accept && running && tw_sel;

  dcs_three_wire u_three_wire (
    .clk(CLOCK),
    .rst(RESET),
    .start_pulse(tw_start),
    .stop_req(tw_stop),
    .preset(tw_preset),
    .running(tw_run)
  );

  // ************************************************
  // run state
  // ************************************************
  logic demand;

  always_comb begin
    case (start_src)
      dcs_pkg::START_CONT: demand = c_cw || c_ccw;
      dcs_pkg::START_KEY: demand = key_run_reg;
      dcs_pkg::START_EITHER: demand = c_cw || c_ccw || key_run_reg;
      dcs_pkg::START_SM: demand = SM_RUN;
      dcs_pkg::START_REM: demand = REM_START_CW || REM_START_CCW;
      dcs_pkg::START_3W: demand = tw_run;
      dcs_pkg::START_3W_KEY: demand = tw_run;
      default: demand = 1'b0;
    endcase
  end

  // hold state during the switch cycle
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      run_state <= dcs_pkg::RUN_STOPPED;
    end else if (!mode_accept) begin
      case (run_state)
        dcs_pkg::RUN_STOPPED: begin
          if (demand) begin
            run_state <= dcs_pkg::RUN_RUNNING;
          end
        end
        dcs_pkg::RUN_RUNNING: begin
          if (!demand) begin
            run_state <= dcs_pkg::RUN_STOPPED;
          end
        end
        default: begin
          run_state <= dcs_pkg::RUN_STOPPED;
        end
      endcase
    end
  end

  assign RUN_CMD = running;

  // ************************************************
  // direction
  // ************************************************
  logic cont_dir_reg;
  logic rem_dir_reg;
  logic key_dir_prev_reg;
  logic either_dir_reg;
  logic cont_dir_next;

  // both or neither start contact keeps the last direction
  always_comb begin
    cont_dir_next = cont_dir_reg;
    if (c_cw && !c_ccw) begin
      cont_dir_next = 1'b0;
    end else if (c_ccw && !c_cw) begin
      cont_dir_next = 1'b1;
    end
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      cont_dir_reg <= dcs_pkg::DIR_RESET;
    end else begin
      cont_dir_reg <= cont_dir_next;
    end
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      rem_dir_reg <= dcs_pkg::DIR_RESET;
    end else if (REM_START_CW && !REM_START_CCW) begin
      rem_dir_reg <= 1'b0;
    end else if (REM_START_CCW && !REM_START_CW) begin
      rem_dir_reg <= 1'b1;
    end
  end

  // the most recent change from either source wins; contacts win a tie
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      key_dir_prev_reg <= dcs_pkg::DIR_RESET;
      either_dir_reg <= dcs_pkg::DIR_RESET;
    end else begin
      key_dir_prev_reg <= KEYPAD_SOURCE_DIR_CCW;
      if (cont_dir_next != cont_dir_reg) begin
        either_dir_reg <= cont_dir_next;
      end else if (KEYPAD_SOURCE_DIR_CCW != key_dir_prev_reg) begin
        either_dir_reg <= KEYPAD_SOURCE_DIR_CCW;
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      DIR_CCW <= dcs_pkg::DIR_RESET;
    end else begin
      case (dir_src)
        dcs_pkg::DIR_CONT: DIR_CCW <= cont_dir_reg;
        dcs_pkg::DIR_KEY: DIR_CCW <= KEYPAD_SOURCE_DIR_CCW;
        dcs_pkg::DIR_EITHER: DIR_CCW <= either_dir_reg;
        dcs_pkg::DIR_SM: DIR_CCW <= SM_DIR_CCW;
        dcs_pkg::DIR_REM: DIR_CCW <= rem_dir_reg;
        dcs_pkg::DIR_FIX_CW: DIR_CCW <= 1'b0;
        dcs_pkg::DIR_FIX_CCW: DIR_CCW <= 1'b1;
        default: DIR_CCW <= dcs_pkg::DIR_RESET;
      endcase
    end
  end

  // ************************************************
  // output stage enable
  // ************************************************
  // both safe-stop inputs high
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      OUTPUT_ENABLE <= 1'b0;
    end else begin
      OUTPUT_ENABLE <= ss_a && ss_b;
    end
  end

endmodule
`default_nettype wire

// file: test/dcs_selector_props.sv
// port checker for the command source selector
// assumes it is bound onto dcs_selector; one clock domain
`timescale 1ns/1ns
`default_nettype none
module dcs_selector_props (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // watched inputs
  input wire logic [7:0] MODE_CODE,
  input wire logic MODE_WRITE,
  input wire logic KEYPAD_SOURCE_STOP,
  input wire logic SM_RUN,
  input wire logic SM_DIR_CCW,
  input wire logic REM_START_CW,
  input wire logic REM_START_CCW,
  input wire logic SAFE_STOP_INPUT_A,
  input wire logic SAFE_STOP_INPUT_B,
  // watched outputs
  input wire logic RUN_CMD,
  input wire logic DIR_CCW,
  input wire logic OUTPUT_ENABLE,
  input wire logic [7:0] ACTIVE_MODE,
  input wire logic MODE_REJECTED
);
  // ****************
  // helpers
  // ****************
  logic [2:0] up_reg;
  logic listed;
  logic cw_mode;
  logic ccw_mode;
  assign listed = MODE_CODE inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h0D,
    8'h0E, 8'h14, 8'h17, 8'h18, 8'h1E, 8'h21, 8'h22, 8'h2B, 8'h2C, 8'h2E};
  assign cw_mode = ACTIVE_MODE inside {8'h14, 8'h17, 8'h18};
  assign ccw_mode = ACTIVE_MODE inside {8'h1E, 8'h21, 8'h22};
  // the pin synchronisers refill after reset before the enable can be judged
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      up_reg <= 3'h0;
    end else if (up_reg != 3'h7) begin
      up_reg <= up_reg + 3'h1;
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);
  sequence s_cw_held;
    cw_mode [*2];
  endsequence
  sequence s_ccw_held;
    ccw_mode [*2];
  endsequence
  sequence s_key_stop;
    (ACTIVE_MODE == 8'h0D && KEYPAD_SOURCE_STOP && !MODE_WRITE) ##1 !MODE_WRITE;
  endsequence
  // ****************
  // assertions
  // ****************
  a_enable_both_high: assert property (
    up_reg > 3'h3 |-> OUTPUT_ENABLE ==
      ($past(SAFE_STOP_INPUT_A, 3) && $past(SAFE_STOP_INPUT_B, 3)))
    else $error("output enable does not follow both safe-stop lines");
  a_mode_accept: assert property (
    MODE_WRITE && listed |=> ACTIVE_MODE == $past(MODE_CODE) && !MODE_REJECTED)
    else $error("listed mode code not taken");
  a_mode_reject: assert property (
    MODE_WRITE && !listed |=> MODE_REJECTED && $stable(ACTIVE_MODE))
    else $error("unlisted mode code not refused");
  a_mode_hold: assert property (
    !MODE_WRITE |=> $stable(ACTIVE_MODE) && !MODE_REJECTED)
    else $error("mode changed without a write");
  a_fixed_cw: assert property (s_cw_held |-> !DIR_CCW)
    else $error("clockwise-only mode shows anticlockwise");
  a_fixed_ccw: assert property (s_ccw_held |-> DIR_CCW)
    else $error("anticlockwise-only mode shows clockwise");
  a_sm_follow: assert property (
    ACTIVE_MODE == 8'h01 && !MODE_WRITE |=>
      RUN_CMD == $past(SM_RUN) && DIR_CCW == $past(SM_DIR_CCW))
    else $error("state machine source not followed");
  a_remote_run: assert property (
    ACTIVE_MODE == 8'h02 && !MODE_WRITE |=>
      RUN_CMD == ($past(REM_START_CW) || $past(REM_START_CCW)))
    else $error("remote contacts not followed");
  a_keypad_stop: assert property (s_key_stop |=> !RUN_CMD)
    else $error("keypad stop did not stop");
  a_swap_keeps: assert property (
    RUN_CMD && MODE_WRITE && MODE_CODE == 8'h03 && ACTIVE_MODE == 8'h0D &&
      !KEYPAD_SOURCE_STOP |=> RUN_CMD)
    else $error("mode change stopped a running drive");
endmodule
bind dcs_selector dcs_selector_props u_dcs_selector_props (
  .CLOCK(CLOCK), .RESET(RESET), .MODE_CODE(MODE_CODE), .MODE_WRITE(MODE_WRITE),
  .KEYPAD_SOURCE_STOP(KEYPAD_SOURCE_STOP), .SM_RUN(SM_RUN), .SM_DIR_CCW(SM_DIR_CCW),
  .REM_START_CW(REM_START_CW), .REM_START_CCW(REM_START_CCW),
  .SAFE_STOP_INPUT_A(SAFE_STOP_INPUT_A), .SAFE_STOP_INPUT_B(SAFE_STOP_INPUT_B),
  .RUN_CMD(RUN_CMD), .DIR_CCW(DIR_CCW), .OUTPUT_ENABLE(OUTPUT_ENABLE),
  .ACTIVE_MODE(ACTIVE_MODE), .MODE_REJECTED(MODE_REJECTED)
);
`default_nettype wire

// file: test/dcs_far_side.sv
// far-side model: operator keypad, control contacts, safe-stop controller
// assumes clk is the controller clock; pins move just after its rising edge
`timescale 1ns/1ns
`default_nettype none
module dcs_far_side (
  // clock
  input wire logic clk,
  // contacts
  output logic cont_cw,
  output logic cont_ccw,
  output logic cont_hold,
  // keypad
  output logic key_start,
  output logic key_stop,
  output logic key_ccw,
  // safe stop
  output logic safe_a,
  output logic safe_b
);
  initial begin
    cont_cw = 1'b0;
    cont_ccw = 1'b0;
    key_start = 1'b0;
    key_stop = 1'b0;
    key_ccw = 1'b0;
    safe_a = 1'b0;
    safe_b = 1'b0;
    cont_hold = 1'b1;
  end
  // keys are one-cycle pulses, as the panel logic hands them over
  task automatic press(input logic stop);
    @(posedge clk);
    if (stop) key_stop <= 1'b1;
    else key_start <= 1'b1;
    @(posedge clk);
    key_stop <= 1'b0;
    key_start <= 1'b0;
  endtask
  task automatic key_dir(input logic ccw);
    @(posedge clk);
    key_ccw <= ccw;
  endtask
  task automatic contacts(input logic cw, input logic ccw, input logic hold);
    @(posedge clk);
    cont_cw <= cw;
    cont_ccw <= ccw;
    cont_hold <= hold;
  endtask
  // controller raises both lines to allow operation
  task automatic safe(input logic a, input logic b);
    @(posedge clk);
    safe_a <= a;
    safe_b <= b;
  endtask
endmodule
`default_nettype wire

// file: test/testbench.sv
// self-checking bench for the command source selector
// assumes dcs_far_side plays keypad, contacts and safe-stop controller
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic CLOCK;
  logic RESET;
  logic [7:0] MODE_CODE;
  logic MODE_WRITE;
  logic SM_RUN;
  logic SM_DIR_CCW;
  logic REM_START_CW;
  logic REM_START_CCW;
  logic cont_cw, cont_ccw, cont_hold, key_start, key_stop, key_ccw, safe_a, safe_b;
  logic run_cmd, dir_ccw, out_en, rejected;
  logic [7:0] act_mode;
  int error_cnt;
  int checks_done;
  // mode, keypad starts, contacts start, direction (2 = not judged)
  logic [11:0] mode_tab [15] = '{12'h005, 12'h012, 12'h022, 12'h039, 12'h04D, 12'h0D8,
    12'h0EC, 12'h144, 12'h178, 12'h18C, 12'h1E5, 12'h219, 12'h22D, 12'h2B9, 12'h2CD};
  logic [7:0] bad_tab [4] = '{8'h1F, 8'h20, 8'h06, 8'hFF};
  dcs_selector u_dcs_selector (
    .CLOCK(CLOCK), .RESET(RESET), .MODE_CODE(MODE_CODE), .MODE_WRITE(MODE_WRITE),
    .CONT_START_CW(cont_cw), .CONT_START_CCW(cont_ccw), .CONT_3W_HOLD(cont_hold),
    .KEYPAD_SOURCE_START(key_start), .KEYPAD_SOURCE_STOP(key_stop),
    .KEYPAD_SOURCE_DIR_CCW(key_ccw), .SM_RUN(SM_RUN), .SM_DIR_CCW(SM_DIR_CCW),
    .REM_START_CW(REM_START_CW), .REM_START_CCW(REM_START_CCW),
    .SAFE_STOP_INPUT_A(safe_a), .SAFE_STOP_INPUT_B(safe_b), .RUN_CMD(run_cmd),
    .DIR_CCW(dir_ccw), .OUTPUT_ENABLE(out_en), .ACTIVE_MODE(act_mode),
    .MODE_REJECTED(rejected)
  );
  dcs_far_side u_dcs_far_side (
    .clk(CLOCK), .cont_cw(cont_cw), .cont_ccw(cont_ccw), .cont_hold(cont_hold),
    .key_start(key_start), .key_stop(key_stop), .key_ccw(key_ccw),
    .safe_a(safe_a), .safe_b(safe_b)
  );
  initial CLOCK = 1'b0;
  always #5 CLOCK = ~CLOCK;
  // ****************
  // tasks
  // ****************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  // samples one step after the edge so that the design's updates have landed
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask
  task automatic set_mode(input logic [7:0] code);
    @(posedge CLOCK);
    MODE_CODE <= code;
    MODE_WRITE <= 1'b1;
    @(posedge CLOCK);
    MODE_WRITE <= 1'b0;
    #1;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge CLOCK);
    error_cnt++;
    results();
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    RESET = 1'b1;
    MODE_CODE = 8'h00;
    MODE_WRITE = 1'b0;
    SM_RUN = 1'b0;
    SM_DIR_CCW = 1'b0;
    REM_START_CW = 1'b0;
    REM_START_CCW = 1'b0;
    error_cnt = 0;
    checks_done = 0;
    repeat (12) @(posedge CLOCK);
    RESET <= 1'b0;
    wait_cyc(1);
    chk("mode after reset", 8'h00, act_mode);
    chk("run after reset", 8'h00, run_cmd);
    for (int i = 0; i < 4; i++) begin
      u_dcs_far_side.safe(i[1], i[0]);
      wait_cyc(4);
      chk("output enable", (i == 3), out_en);
    end
    foreach (mode_tab[i]) begin
      set_mode(mode_tab[i][11:4]);
      chk("active mode", mode_tab[i][11:4], act_mode);
      chk("reject flag", 8'h00, rejected);
      u_dcs_far_side.press(1'b0);
      wait_cyc(3);
      chk("keypad run", mode_tab[i][3], run_cmd);
      u_dcs_far_side.press(1'b1);
      u_dcs_far_side.contacts(1'b0, 1'b1, 1'b1);
      wait_cyc(5);
      chk("contact run", mode_tab[i][2], run_cmd);
      if (mode_tab[i][1:0] != 2'h2) chk("direction", mode_tab[i][1:0], dir_ccw);
      u_dcs_far_side.contacts(1'b0, 1'b0, 1'b1);
      wait_cyc(5);
    end
    foreach (bad_tab[i]) begin
      set_mode(bad_tab[i]);
      chk("reject flag", 8'h01, rejected);
      chk("mode kept", 8'h2C, act_mode);
    end
    set_mode(8'h01);
    @(posedge CLOCK);
    SM_RUN <= 1'b1;
    SM_DIR_CCW <= 1'b1;
    wait_cyc(2);
    chk("sm run", 8'h01, run_cmd);
    chk("sm direction", 8'h01, dir_ccw);
    set_mode(8'h02);
    wait_cyc(2);
    chk("remote idle run", 8'h00, run_cmd);
    @(posedge CLOCK);
    REM_START_CCW <= 1'b1;
    wait_cyc(2);
    chk("remote run", 8'h01, run_cmd);
    chk("remote ccw", 8'h01, dir_ccw);
    @(posedge CLOCK);
    REM_START_CCW <= 1'b0;
    REM_START_CW <= 1'b1;
    wait_cyc(2);
    chk("remote run cw", 8'h01, run_cmd);
    chk("remote direction", 8'h00, dir_ccw);
    @(posedge CLOCK);
    SM_RUN <= 1'b0;
    SM_DIR_CCW <= 1'b0;
    REM_START_CW <= 1'b0;
    set_mode(8'h0D);
    u_dcs_far_side.press(1'b0);
    u_dcs_far_side.key_dir(1'b1);
    wait_cyc(3);
    chk("keypad run", 8'h01, run_cmd);
    chk("keypad direction", 8'h01, dir_ccw);
    set_mode(8'h03);
    wait_cyc(3);
    chk("run kept", 8'h01, run_cmd);
    set_mode(8'h00);
    wait_cyc(3);
    chk("run dropped", 8'h00, run_cmd);
    u_dcs_far_side.press(1'b1);
    set_mode(8'h05);
    u_dcs_far_side.contacts(1'b1, 1'b0, 1'b1);
    wait_cyc(5);
    chk("three-wire run", 8'h01, run_cmd);
    chk("three-wire direction", 8'h00, dir_ccw);
    u_dcs_far_side.contacts(1'b0, 1'b0, 1'b1);
    wait_cyc(5);
    chk("three-wire latched", 8'h01, run_cmd);
    u_dcs_far_side.contacts(1'b0, 1'b0, 1'b0);
    wait_cyc(5);
    chk("three-wire stop", 8'h00, run_cmd);
    set_mode(8'h2E);
    u_dcs_far_side.contacts(1'b0, 1'b0, 1'b1);
    wait_cyc(3);
    u_dcs_far_side.press(1'b0);
    wait_cyc(3);
    chk("mixed keypad run", 8'h01, run_cmd);
    u_dcs_far_side.press(1'b1);
    wait_cyc(3);
    chk("mixed keypad stop", 8'h00, run_cmd);
    results();
  end
endmodule
`default_nettype wire
